// [src/cmd_pulse_defs.svh]
// constants for the command pulse decoder
`ifndef CMD_PULSE_DEFS_SVH
`define CMD_PULSE_DEFS_SVH

// power-up values of the settings
`define CPD_IFACE_RESET       2'h0
`define CPD_INVERT_RESET      1'h0
`define CPD_FORMAT_RESET      2'h1

// clock rate in MHz
`define CPD_CLK_MHZ           25

// least pulse widths on the photocoupler path, in ns
`define CPD_OPTO_LD_MIN_NS    1000
`define CPD_OPTO_OC_MIN_NS    2500

// filter settle time is half the least width, rounded down, never below one cycle
`define CPD_LD_FILT_CYC       (((`CPD_OPTO_LD_MIN_NS * `CPD_CLK_MHZ) / 2000) > 0 ? \
                               ((`CPD_OPTO_LD_MIN_NS * `CPD_CLK_MHZ) / 2000) : 1)
`define CPD_OC_FILT_CYC       (((`CPD_OPTO_OC_MIN_NS * `CPD_CLK_MHZ) / 2000) > 0 ? \
                               ((`CPD_OPTO_OC_MIN_NS * `CPD_CLK_MHZ) / 2000) : 1)

`endif

// [src/cmd_pulse_pkg.sv]
// types shared by the command pulse decoder
package cmd_pulse_pkg;

	// which pin group feeds the decoder
	typedef enum logic [1:0] {
		IFACE_OPTO_ANY  = 2'b00,
		IFACE_FAST_LD   = 2'b01,
		IFACE_OPTO_OC   = 2'b10,
		IFACE_UNUSED    = 2'b11
	} iface_t;

	// pulse input format
	typedef enum logic [1:0] {
		FMT_QUAD_0      = 2'b00,
		FMT_DUAL_TRAIN  = 2'b01,
		FMT_QUAD_2      = 2'b10,
		FMT_PULSE_SIGN  = 2'b11
	} format_t;

	// one pin group: differential pulse and sign pairs
	typedef struct packed {
		logic pulse_p;
		logic pulse_n;
		logic sign_p;
		logic sign_n;
	} pin_group_t;

	// settings in force
	typedef struct packed {
		iface_t  iface;
		logic    invert;
		format_t format;
	} settings_t;

endpackage

// [src/sync_two_stage.sv]
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps

module sync_two_stage #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] next_stage_one;
	logic [WIDTH-1:0] next_sync_out;

	initial begin
		if (WIDTH < 1) begin
			$error("sync_two_stage: WIDTH must be at least 1");
		end
	end

	// first stage is read only by the second
	always_comb begin
		next_stage_one = async_in;
		next_sync_out  = stage_one;
	end

	// register both stages
	always_ff @(posedge clk) begin
		if (reset) begin
			stage_one <= '0;
			sync_out  <= '0;
		end else begin
			stage_one <= next_stage_one;
			sync_out  <= next_sync_out;
		end
	end

endmodule

// [src/command_pulse_decoder.sv]
// command pulse decoder: pin group select, filtering, format decode and position count
// Notes on behaviour
// - interface selection setting, values 0 to 2, defaults to 0.
// - pulse source is the photocoupler group or the line-driver group.
// - selection 0 uses photocoupler pins, line-driver or open-collector sources.
// - selection 1 uses only the fast line-driver pins, highest pulse rate.
// - one-bit direction setting, defaults to 0, picks the positive pattern.
// - format setting 0 to 3, default 1: quadrature, dual train, pulse+sign.
// - direction 1 swaps positive and negative counting in every format.
// - count only on the transitions the selected format defines.
// - quadrature, direction 0: B leading A counts positive, lagging negative.
// - quadrature, direction 1: B lagging A counts positive, leading negative.
// - quadrature counts all four edges; single-pulse formats one per pulse.
// - settings take effect only at the next power-up reset.
`timescale 1ns/1ps
`include "cmd_pulse_defs.svh"

module command_pulse_decoder
	import cmd_pulse_pkg::*;
#(
	parameter int COUNT_W = 32,
	parameter int FILT_W  = 6
) (
	// clock and reset (reset marks control power-up)
	input  wire logic               clk,
	input  wire logic               reset,
	// photocoupler pin group
	input  wire logic               opto_pulse_in_a,
	input  wire logic               opto_pulse_in_b,
	input  wire logic               opto_sign_in_a,
	input  wire logic               opto_sign_in_b,
	// dedicated line-driver pin group
	input  wire logic               fast_pulse_in_p,
	input  wire logic               fast_pulse_in_n,
	input  wire logic               fast_sign_in_p,
	input  wire logic               fast_sign_in_n,
	// requested settings, taken only at power-up
	input  wire logic [1:0]         input_interface_select,
	input  wire logic               count_direction_invert,
	input  wire logic [1:0]         pulse_format_select,
	// settings in force
	output settings_t               active_settings,
	// decoded counts
	output logic                    count_up,
	output logic                    count_down,
	output logic                    phase_error,
	output logic signed [COUNT_W-1:0] position_count
);

	localparam logic [FILT_W-1:0] LD_FILT = FILT_W'(`CPD_LD_FILT_CYC);
	localparam logic [FILT_W-1:0] OC_FILT = FILT_W'(`CPD_OC_FILT_CYC);

	initial begin
		if (COUNT_W < 2) begin
			$error("command_pulse_decoder: COUNT_W must be at least 2");
		end
		if ((`CPD_OC_FILT_CYC >= (1 << FILT_W)) || (`CPD_LD_FILT_CYC >= (1 << FILT_W))) begin
			$error("command_pulse_decoder: FILT_W too narrow for filter counts");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	pin_group_t opto_pins;
	pin_group_t fast_pins;
	pin_group_t opto_sync;
	pin_group_t fast_sync;

	assign opto_pins = '{opto_pulse_in_a, opto_pulse_in_b, opto_sign_in_a, opto_sign_in_b};
	assign fast_pins = '{fast_pulse_in_p, fast_pulse_in_n, fast_sign_in_p, fast_sign_in_n};

	sync_two_stage #(.WIDTH(4)) u_sync_opto (
		.clk      (clk),
		.reset    (reset),
		.async_in (opto_pins),
		.sync_out (opto_sync)
	);

	sync_two_stage #(.WIDTH(4)) u_sync_fast (
		.clk      (clk),
		.reset    (reset),
		.async_in (fast_pins),
		.sync_out (fast_sync)
	);

	// receiver levels: current flows from the a/p leg to the b/n leg
	logic [1:0] opto_raw;
	logic [1:0] fast_level;
	assign opto_raw   = {opto_sync.pulse_p & ~opto_sync.pulse_n,
	                     opto_sync.sign_p & ~opto_sync.sign_n};
	assign fast_level = {fast_sync.pulse_p & ~fast_sync.pulse_n,
	                     fast_sync.sign_p & ~fast_sync.sign_n};

	////////////////////////////////////////////////////////////////////////////////
	// settings, caught once after power-up reset

	settings_t  next_active_settings;
	logic       load_pending;
	logic       next_load_pending;
	settings_t  requested;

	// illegal interface code 3 falls back to the default group
	always_comb begin
		requested.iface  = (input_interface_select == 2'h3) ? iface_t'(`CPD_IFACE_RESET)
		                                                    : iface_t'(input_interface_select);
		requested.invert = count_direction_invert;
		requested.format = format_t'(pulse_format_select);
	end

	always_comb begin
		next_load_pending    = 1'b0;
		next_active_settings = active_settings;
		if (load_pending) begin
			next_active_settings = requested;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			load_pending           <= 1'b1;
			active_settings.iface  <= iface_t'(`CPD_IFACE_RESET);
			active_settings.invert <= `CPD_INVERT_RESET;
			active_settings.format <= format_t'(`CPD_FORMAT_RESET);
		end else begin
			load_pending    <= next_load_pending;
			active_settings <= next_active_settings;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// photocoupler glitch filter, settle time set by the interface choice

	logic [FILT_W-1:0] filt_limit;
	logic [1:0]        opto_filt;
	logic [1:0]        next_opto_filt;
	logic [FILT_W-1:0] filt_cnt      [2];
	logic [FILT_W-1:0] next_filt_cnt [2];

	// slower open-collector edges get the longer settle time
	assign filt_limit = (active_settings.iface == IFACE_OPTO_OC) ? OC_FILT : LD_FILT;

	// a level passes once it has held for the settle time
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_opto_filt[i] = opto_filt[i];
			next_filt_cnt[i]  = '0;
			if (opto_raw[i] != opto_filt[i]) begin
				if (filt_cnt[i] + FILT_W'(1) >= filt_limit) begin
					next_opto_filt[i] = opto_raw[i];
				end else begin
					next_filt_cnt[i] = filt_cnt[i] + FILT_W'(1);
				end
			end
		end
	end

	// register the filter
	always_ff @(posedge clk) begin
		if (reset) begin
			opto_filt   <= 2'h0;
			filt_cnt[0] <= '0;
			filt_cnt[1] <= '0;
		end else begin
			opto_filt   <= next_opto_filt;
			filt_cnt[0] <= next_filt_cnt[0];
			filt_cnt[1] <= next_filt_cnt[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// source select and format decode

	logic [1:0] sel_level;
	logic [1:0] prev_level;
	logic       next_count_up;
	logic       next_count_down;
	logic       next_phase_error;
	logic       pos_evt;
	logic       neg_evt;
	logic       a_cur, b_cur, a_prev, b_prev;

	// selection 1 bypasses the photocoupler group entirely
	assign sel_level = (active_settings.iface == IFACE_FAST_LD) ? fast_level : opto_filt;

	assign a_cur  = sel_level[1];
	assign b_cur  = sel_level[0];
	assign a_prev = prev_level[1];
	assign b_prev = prev_level[0];

	// only the format's own transitions produce a count
	always_comb begin
		pos_evt          = 1'b0;
		neg_evt          = 1'b0;
		next_phase_error = 1'b0;
		case (active_settings.format)
			FMT_QUAD_0, FMT_QUAD_2: begin
				// every single-phase edge counts, four per cycle
				if ((a_cur != a_prev) ^ (b_cur != b_prev)) begin
					// B leading A gives a_prev xor b_cur high
					pos_evt = a_prev ^ b_cur;
					neg_evt = ~(a_prev ^ b_cur);
				end else if ((a_cur != a_prev) && (b_cur != b_prev)) begin
					next_phase_error = 1'b1;
				end
			end
			FMT_DUAL_TRAIN: begin
				// first input positive, second negative; coincident edges cancel
				pos_evt = a_cur & ~a_prev & ~(b_cur & ~b_prev);
				neg_evt = b_cur & ~b_prev & ~(a_cur & ~a_prev);
			end
			FMT_PULSE_SIGN: begin
				// rising pulse edge, sign level high means positive
				pos_evt = a_cur & ~a_prev & b_cur;
				neg_evt = a_cur & ~a_prev & ~b_cur;
			end
			default: begin
				pos_evt = 1'b0;
				neg_evt = 1'b0;
			end
		endcase
	end

	// direction 1 swaps the two senses
	// quadrature with direction 1 counts B lagging as positive
	always_comb begin
		next_count_up   = 1'b0;
		next_count_down = 1'b0;
		if (!load_pending) begin
			next_count_up   = active_settings.invert ? neg_evt : pos_evt;
			next_count_down = active_settings.invert ? pos_evt : neg_evt;
		end
	end

	// register decode outputs and the previous levels
	always_ff @(posedge clk) begin
		if (reset) begin
			prev_level  <= 2'h0;
			count_up    <= 1'b0;
			count_down  <= 1'b0;
			phase_error <= 1'b0;
		end else begin
			prev_level  <= sel_level;
			count_up    <= next_count_up;
			count_down  <= next_count_down;
			phase_error <= next_phase_error & ~load_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// position counter

	logic signed [COUNT_W-1:0] next_position_count;

	always_comb begin
		next_position_count = position_count;
		if (next_count_up) begin
			next_position_count = position_count + COUNT_W'(1);
		end else if (next_count_down) begin
			next_position_count = position_count - COUNT_W'(1);
		end
	end

	// register the count
	always_ff @(posedge clk) begin
		if (reset) begin
			position_count <= '0;
		end else begin
			position_count <= next_position_count;
		end
	end

endmodule

// [dv/cpd_sva.sv]
// port checker for the command pulse decoder
`timescale 1ns/1ps

module cpd_sva
	import cmd_pulse_pkg::*;
#(
	parameter int COUNT_W = 32
) (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      reset,
	// requested settings
	input wire logic                      count_direction_invert,
	input wire logic [1:0]                pulse_format_select,
	// decoder outputs
	input wire settings_t                 active_settings,
	input wire logic                      count_up,
	input wire logic                      count_down,
	input wire logic                      phase_error,
	input wire logic signed [COUNT_W-1:0] position_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////
	// count pulses and the running count
	chk_one_sign: assert property (!(count_up && count_down))
		else $error("up and down in one cycle");
	chk_up_step: assert property (count_up |-> position_count == $past(position_count) + 1)
		else $error("count did not rise by one");
	chk_down_step: assert property (count_down |-> position_count == $past(position_count) - 1)
		else $error("count did not fall by one");
	chk_count_idle: assert property (!count_up && !count_down |-> $stable(position_count))
		else $error("count moved without a pulse");
	chk_start_zero: assert property ($fell(reset) |-> position_count == 0 && !count_up)
		else $error("count not clear after reset");
	chk_phase_quiet: assert property (phase_error |-> !count_up && !count_down)
		else $error("count on a double phase change");

	////////////////////////////////////////////////////////////////////////
	// settings taken once after reset
	chk_set_load: assert property ($fell(reset) |=>
		active_settings.invert == $past(count_direction_invert) &&
		active_settings.format == $past(pulse_format_select))
		else $error("settings not loaded");
	chk_set_hold: assert property (!$past(reset) && !$past(reset, 2)
		|-> $stable(active_settings))
		else $error("settings changed after load");
	chk_iface_legal: assert property (active_settings.iface != IFACE_UNUSED)
		else $error("unused interface code in force");
endmodule

// [dv/host_pulse_gen.sv]
// host controller model driving command pulses on the pin group chosen by use_fast, noise on the other
`timescale 1ns/1ps

module host_pulse_gen (
	// clock and group choice
	input wire logic clk,
	input wire logic use_fast,
	// photocoupler pins
	output logic     opto_pulse_in_a,
	output logic     opto_pulse_in_b,
	output logic     opto_sign_in_a,
	output logic     opto_sign_in_b,
	// line-driver pins
	output logic     fast_pulse_in_p,
	output logic     fast_pulse_in_n,
	output logic     fast_sign_in_p,
	output logic     fast_sign_in_n
);
	logic       pl = 1'b0;
	logic       sl = 1'b0;
	logic [1:0] q = 2'h0;
	logic [1:0] noise = 2'h0;

	// the unused group sees a pattern that changes every cycle
	always @(negedge clk) noise <= noise + 2'h1;

	// chosen group carries differential levels
	assign opto_pulse_in_a = use_fast ? noise[0] : pl;
	assign opto_pulse_in_b = use_fast ? noise[1] : !pl;
	assign opto_sign_in_a  = use_fast ? noise[1] : sl;
	assign opto_sign_in_b  = use_fast ? noise[0] : !sl;
	assign fast_pulse_in_p = use_fast ? pl : noise[0];
	assign fast_pulse_in_n = use_fast ? !pl : noise[1];
	assign fast_sign_in_p  = use_fast ? sl : noise[1];
	assign fast_sign_in_n  = use_fast ? !sl : noise[0];

	////////////////////////////////////////////////////////////////////////
	task automatic idle();
		pl = 1'b0;
		sl = 1'b0;
		q = 2'h0;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask

	// one count: quadrature step, own-train pulse, or sign then pulse
	task automatic move(input logic up, input logic [1:0] fmt, input int hold);
		if (!fmt[0]) begin
			q = up ? q + 2'h1 : q - 2'h1;
			pl = q[1];
			sl = q[1] ^ q[0];
			wait_n(hold);
		end else if (fmt == 2'h1) begin
			if (up) pl = 1'b1;
			else sl = 1'b1;
			wait_n(hold);
			pl = 1'b0;
			sl = 1'b0;
			wait_n(hold);
		end else begin
			sl = up;
			wait_n(hold);
			pl = 1'b1;
			wait_n(hold);
			pl = 1'b0;
			wait_n(hold);
		end
	endtask

	// both phases at once: a quadrature step the decoder must refuse
	task automatic jump(input int hold);
		q = q + 2'h2;
		pl = q[1];
		sl = q[1] ^ q[0];
		wait_n(hold);
	endtask

	// short flip of the pulse line that a filter must drop
	task automatic glitch(input int w);
		pl = !pl;
		wait_n(w);
		pl = !pl;
		wait_n(40);
	endtask
endmodule

// [dv/tb_top.sv]
// self-checking bench for the command pulse decoder
`timescale 1ns/1ps

module tb_top;
	import cmd_pulse_pkg::*;
	logic               clk = 1'b0;
	logic               reset = 1'b1;
	logic               use_fast = 1'b0;
	logic [1:0]         input_interface_select = 2'h0;
	logic               count_direction_invert = 1'b0;
	logic [1:0]         pulse_format_select = 2'h1;
	logic               opto_pulse_in_a, opto_pulse_in_b, opto_sign_in_a, opto_sign_in_b;
	logic               fast_pulse_in_p, fast_pulse_in_n, fast_sign_in_p, fast_sign_in_n;
	settings_t          active_settings;
	logic               count_up, count_down, phase_error;
	logic signed [31:0] position_count, exp_pos;
	int                 err_total = 0;
	int                 cmp_count = 0;
	int                 seed = 32'h2975;
	int                 up_seen = 0;
	int                 down_seen = 0;
	int                 perr_seen = 0;

	initial forever #20 clk = !clk;

	// tally one-cycle pulses where they have settled
	always @(negedge clk) begin
		if (count_up === 1'b1) up_seen++;
		if (count_down === 1'b1) down_seen++;
		if (phase_error === 1'b1) perr_seen++;
	end

	host_pulse_gen host (.clk, .use_fast, .opto_pulse_in_a, .opto_pulse_in_b,
		.opto_sign_in_a, .opto_sign_in_b, .fast_pulse_in_p, .fast_pulse_in_n,
		.fast_sign_in_p, .fast_sign_in_n);

	command_pulse_decoder uut (.clk, .reset, .opto_pulse_in_a, .opto_pulse_in_b,
		.opto_sign_in_a, .opto_sign_in_b, .fast_pulse_in_p, .fast_pulse_in_n,
		.fast_sign_in_p, .fast_sign_in_n, .input_interface_select,
		.count_direction_invert, .pulse_format_select, .active_settings,
		.count_up, .count_down, .phase_error, .position_count);

	////////////////////////////////////////////////////////////////////////
	function automatic int delta(input logic d, input logic inv);
		return (d ^ inv) ? 1 : -1;
	endfunction

	task automatic check(input logic ok, input string what);
		cmp_count++;
		if (!ok) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// reset with one setting set, scramble the requests, send random moves
	task automatic run_cfg(input logic [1:0] i, input logic v, input logic [1:0] f);
		int        hold;
		int        n;
		logic      d;
		settings_t want;
		int        exp_up;
		int        exp_dn;
		int        exp_pe;
		int        up0;
		int        dn0;
		int        pe0;
		hold = (i == 2'h1) ? 3 : 40;
		exp_up = 0;
		exp_dn = 0;
		exp_pe = 0;
		n = 8 + ($random(seed) & 7);
		want = {(i == 2'h3) ? 2'h0 : i, v, f};
		@(negedge clk);
		reset = 1'b1;
		input_interface_select = i;
		count_direction_invert = v;
		pulse_format_select = f;
		use_fast = (i == 2'h1);
		host.idle();
		repeat (8) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		check(active_settings === want, "settings load");
		up0 = up_seen;
		dn0 = down_seen;
		pe0 = perr_seen;
		{input_interface_select, count_direction_invert, pulse_format_select} = 5'($random(seed));
		exp_pos = 0;
		repeat (n) begin
			d = 1'($random(seed));
			host.move(d, f, hold);
			exp_pos += delta(d, v);
			if (d ^ v) exp_up++;
			else exp_dn++;
		end
		if (!f[0]) begin
			host.jump(hold);
			exp_pe = 1;
		end
		if (i != 2'h1) host.glitch(4);
		repeat (50) @(negedge clk);
		check(position_count === exp_pos, "position count");
		check(up_seen - up0 == exp_up, "up pulses");
		check(down_seen - dn0 == exp_dn, "down pulses");
		check(perr_seen - pe0 == exp_pe, "phase error pulses");
		check(active_settings === want, "settings held");
		$display("test iface %0d inv %0d fmt %0d done", i, v, f);
	endtask

	////////////////////////////////////////////////////////////////////////
	// every interface code, direction and format; code 2 is the open-collector host
	initial begin
		for (int i = 0; i < 4; i++)
			for (int v = 0; v < 2; v++)
				for (int f = 0; f < 4; f++)
					run_cfg(2'(i), 1'(v), 2'(f));
		summarize();
	end

	// watchdog against a hang, well above the longest run of about 30k cycles
	initial begin
		#2000000;
		err_total++;
		summarize();
	end
endmodule

bind command_pulse_decoder cpd_sva #(.COUNT_W(COUNT_W)) chk (.clk, .reset,
	.count_direction_invert, .pulse_format_select, .active_settings,
	.count_up, .count_down, .phase_error, .position_count);
